//--- core/pmc_macrocell.sv
// One programmable logic cell: switch matrix, term array, term selector,
// OR/XOR/cascade sum, storage element, output, feedback, foldback and pin enable.
// Assumes all configuration is static and all inputs are synchronous to clk.
// Operation
// - Each cell forms exactly five programmable AND product terms.
// - Product terms see every routed global signal and every regional foldback.
// - A static selector sends each term to the sum or a control.
// - OR sums routed terms; cascade input chains sums up to forty terms.
// - XOR second input is a term, constant high or constant low.
// - Storage data comes from XOR, a dedicated term, or the pin.
// - Storage acts as D, T, JK, SR flip-flop or flow-through latch.
// - Latch passes data while clock high, holds while clock low.
// - Clock is the global line or a term; updates on rising edge.
// - With global clock, an enabled low clock-enable term blocks all edges.
// - Clear is global line, a term, their OR, or off.
// - Set is a term or off.
// - Output and buried feedback each pick registered or combinational independently.
// - Pin enable: either enable pin true or inverted, pin subset, cell subset.
// - Input-only pin still leaves feedback, foldback and cascade usable.
// - Global bus carries all pins plus feedback of all 128 cells.
// - Switch matrix picks at most forty global signals per block.
// - Each cell drives one inverted term onto a sixteen-cell regional bus.
// - Reset initialises storage and every output register low, whatever the selected polarity.
`timescale 1ns/1ps
module pmc_macrocell
    import pmc_pkg::*;
#(
    parameter int NUM_PINS  = `PMC_PINS,
    parameter int NUM_CELLS = `PMC_CELLS,
    parameter int MATRIX_IN = `PMC_MATRIX_IN,
    parameter int REGION    = `PMC_REGION
) (
    // Clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    sys_rst,
    // Static configuration
    input  pmc_cfg_t                                     cfg,
    input  wire logic [MATRIX_IN-1:0][`PMC_SEL_W-1:0]    matrix_sel,
    input  wire logic [`PMC_NUM_PT-1:0][MATRIX_IN+REGION-1:0] pt_use_true,
    input  wire logic [`PMC_NUM_PT-1:0][MATRIX_IN+REGION-1:0] pt_use_comp,
    input  wire logic [NUM_PINS-1:0]                     oe_pin_mask,
    input  wire logic [NUM_CELLS-1:0]                    oe_cell_mask,
    // Shared routing and global lines
    input  wire logic [NUM_PINS+NUM_CELLS-1:0]           global_bus,
    input  wire logic [REGION-1:0]                       foldback_bus,
    input  wire logic                                    cascade_input,
    input  wire logic                                    global_clock_line,
    input  wire logic                                    global_clear_line,
    input  wire logic [`PMC_OE_PINS-1:0]                 oe_pins,
    // Own I/O pin
    input  wire logic                                    pin_in,
    output logic                                         pin_out,
    output logic                                         pin_oe,
    // Cell outputs to neighbours and buses
    output logic                                         cascade_out,
    output logic                                         foldback_out,
    output logic                                         feedback_out
);
    localparam int N_PT  = `PMC_NUM_PT;
    localparam int BUS_W = NUM_PINS + NUM_CELLS;
    localparam int PT_IN = MATRIX_IN + REGION;

    logic [MATRIX_IN-1:0] mtx_in;
    logic [N_PT-1:0]      pts;
    logic                 sum;
    logic                 xor_b;
    logic                 xor_out;
    logic                 din;
    logic                 ce_term;
    logic                 clr_term;
    logic                 set_term;
    logic                 oe_src;
    logic                 fold_term;
    logic                 q;
    pmc_ctl_t             ctl;

    // Out-of-range selects read low rather than X
    function automatic logic bus_pick(input logic [BUS_W-1:0] bus,
                                      input logic [`PMC_SEL_W-1:0] sel);
        return (int'(sel) < BUS_W) ? bus[sel] : 1'b0;
    endfunction : bus_pick

    // OR of every term whose static destination matches
    function automatic logic pt_route(input logic [N_PT-1:0] p,
                                      input pmc_pt_dest_t [N_PT-1:0] dest,
                                      input pmc_pt_dest_t target);
        logic r;
        r = 1'b0;
        for (int i = 0; i < N_PT; i++) begin
            r = r | (p[i] & (dest[i] == target));
        end
        return r;
    endfunction : pt_route

    // Switch matrix
    always_comb begin
        for (int i = 0; i < MATRIX_IN; i++) begin
            mtx_in[i] = bus_pick(global_bus, matrix_sel[i]);
        end
    end

    pmc_pterm_array #(
        .N_PT (N_PT),
        .N_IN (PT_IN)
    ) u_terms (
        .in_bus   ({foldback_bus, mtx_in}),
        .use_true (pt_use_true),
        .use_comp (pt_use_comp),
        .pt       (pts)
    );

    // Sum, polarity and data path
    always_comb begin
        sum = pt_route(pts, cfg.pt_dest, PMC_PT_SUM)
            | (cfg.casc_en & cascade_input);
        unique case (cfg.xor_sel)
            PMC_XOR_PT:   xor_b = pt_route(pts, cfg.pt_dest, PMC_PT_XOR);
            PMC_XOR_HIGH: xor_b = 1'b1;
            PMC_XOR_LOW:  xor_b = 1'b0;
            default:      xor_b = 1'b0;
        endcase
        xor_out = sum ^ xor_b;
        unique case (cfg.din_sel)
            PMC_DIN_XOR: din = xor_out;
            PMC_DIN_PT:  din = pt_route(pts, cfg.pt_dest, PMC_PT_DIN);
            PMC_DIN_PIN: din = pin_in;
            default:     din = 1'b0;
        endcase
    end

    // Storage controls
    always_comb begin
        ce_term  = pt_route(pts, cfg.pt_dest, PMC_PT_CE);
        clr_term = pt_route(pts, cfg.pt_dest, PMC_PT_CLR);
        set_term = pt_route(pts, cfg.pt_dest, PMC_PT_SET);
        ctl.d    = din;
        // JK and SR take their second input from the XOR-bound term
        ctl.aux  = pt_route(pts, cfg.pt_dest, PMC_PT_XOR);
        ctl.clk_lvl = (cfg.clk_sel == PMC_CLK_GLOBAL) ? global_clock_line
                    : pt_route(pts, cfg.pt_dest, PMC_PT_CLK);
        ctl.ce   = (cfg.clk_sel == PMC_CLK_GLOBAL && cfg.ce_en) ? ce_term : 1'b1;
        unique case (cfg.clr_sel)
            PMC_CLR_GLOBAL: ctl.clr = global_clear_line;
            PMC_CLR_PT:     ctl.clr = clr_term;
            PMC_CLR_BOTH:   ctl.clr = global_clear_line | clr_term;
            PMC_CLR_OFF:    ctl.clr = 1'b0;
        endcase
        ctl.set = (cfg.set_sel == PMC_SET_PT) ? set_term : 1'b0;
    end

    pmc_store u_store (
        .clk     (clk),
        .sys_rst (sys_rst),
        .mode    (cfg.ff_mode),
        .ctl     (ctl),
        .q       (q)
    );

    // Pin enable source
    always_comb begin
        unique case (cfg.oe_sel)
            PMC_OE_TRUE:  oe_src = oe_pins[cfg.oe_pin_idx];
            PMC_OE_COMP:  oe_src = ~oe_pins[cfg.oe_pin_idx];
            PMC_OE_PINS:  oe_src = |(global_bus[NUM_PINS-1:0] & oe_pin_mask);
            PMC_OE_CELLS: oe_src = |(global_bus[BUS_W-1:NUM_PINS] & oe_cell_mask);
        endcase
        fold_term = (int'(cfg.fold_sel) < N_PT) ? pts[cfg.fold_sel] : 1'b0;
    end

    // Every output is registered; combinational paths therefore show one clock late
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= cfg.out_reg ? q : xor_out;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            feedback_out <= 1'b0;
        end else begin
            feedback_out <= cfg.fb_reg ? q : xor_out;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= cfg.input_only ? 1'b0 : oe_src;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cascade_out <= 1'b0;
        end else begin
            cascade_out <= sum;
        end
    end

    // Neighbours sharing the region OR these to build sums of up to 21 terms
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            foldback_out <= 1'b0;
        end else begin
            foldback_out <= ~fold_term;
        end
    end

    // Helper for checks: last sample of the selected clock
    logic clk_lvl_d;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_lvl_d <= 1'b0;
        end else begin
            clk_lvl_d <= ctl.clk_lvl;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_cascade_sum: assert property (cfg.casc_en && cascade_input |=> cascade_out)
        else $error("cascade input not summed");
    a_xor_invert: assert property (!cfg.out_reg && cfg.xor_sel == PMC_XOR_HIGH
        |=> pin_out == !$past(sum))
        else $error("constant high did not invert sum");
    // Selects past the last term give a constant-high foldback, so only legal selects are checked
    a_fold_inverse: assert property (int'(cfg.fold_sel) < N_PT && pts[cfg.fold_sel]
        |=> !foldback_out)
        else $error("foldback not inverted term");
    a_fold_idle: assert property (int'(cfg.fold_sel) < N_PT && !pts[cfg.fold_sel]
        |=> foldback_out)
        else $error("foldback not high for low term");
    a_latch_follow: assert property (cfg.ff_mode == PMC_FF_LATCH && ctl.clk_lvl
        && !ctl.clr && !ctl.set |=> q == $past(din))
        else $error("latch not transparent");
    a_latch_hold: assert property (cfg.ff_mode == PMC_FF_LATCH && !ctl.clk_lvl
        && !ctl.clr && !ctl.set |=> $stable(q))
        else $error("latch changed while clock low");
    a_edge_capture: assert property (cfg.ff_mode == PMC_FF_D && ctl.clk_lvl && !clk_lvl_d
        && ctl.ce && !ctl.clr && !ctl.set |=> q == $past(din))
        else $error("rising edge not captured");
    a_no_edge_hold: assert property (cfg.ff_mode != PMC_FF_LATCH && !(ctl.clk_lvl && !clk_lvl_d)
        && !ctl.clr && !ctl.set |=> $stable(q))
        else $error("flip-flop moved without edge");
    a_ce_block: assert property (cfg.ff_mode != PMC_FF_LATCH && cfg.clk_sel == PMC_CLK_GLOBAL
        && cfg.ce_en && !ce_term && !ctl.clr && !ctl.set |=> $stable(q))
        else $error("edge taken while enable low");
    a_clear_both: assert property (cfg.clr_sel == PMC_CLR_BOTH
        && (global_clear_line || clr_term) |=> !q)
        else $error("combined clear ignored");
    a_set_term: assert property (cfg.set_sel == PMC_SET_PT && set_term && !ctl.clr |=> q)
        else $error("set term ignored");
    a_set_off: assert property (cfg.set_sel == PMC_SET_OFF && cfg.ff_mode == PMC_FF_D
        && !q && !ctl.clk_lvl |=> !q)
        else $error("set acted while off");
    a_fb_reg: assert property (cfg.fb_reg && !cfg.out_reg |=> feedback_out == $past(q)
        && pin_out == $past(xor_out))
        else $error("feedback and output not independent");
    a_input_only: assert property (cfg.input_only |=> !pin_oe ##1 !pin_oe
        or !cfg.input_only)
        else $error("input-only pin driven");
    a_oe_comp: assert property (!cfg.input_only && cfg.oe_sel == PMC_OE_COMP
        && &oe_pins |=> !pin_oe)
        else $error("complemented enable wrong");
    a_din_pin: assert property (cfg.din_sel == PMC_DIN_PIN && cfg.ff_mode == PMC_FF_LATCH
        && ctl.clk_lvl && !ctl.clr && !ctl.set |=> q == $past(pin_in))
        else $error("pin not taken as data");

    c_latch_pass: cover property (cfg.ff_mode == PMC_FF_LATCH && ctl.clk_lvl ##1 ctl.clk_lvl);
    c_cascade_on: cover property (cfg.casc_en && cascade_input ##1 cascade_out);
    c_ce_blocked: cover property (cfg.ce_en && !ce_term && ctl.clk_lvl && !clk_lvl_d);
    c_clear_hit: cover property (ctl.clr && q);
    c_clear_term: cover property (cfg.clr_sel == PMC_CLR_BOTH && clr_term && q);
endmodule : pmc_macrocell

//--- core/pmc_pterm_array.sv
// Programmable AND array: each term is the AND of chosen true and inverted inputs.
// Masks are static; a term with no input chosen is constant high.
`timescale 1ns/1ps
module pmc_pterm_array #(
    parameter int N_PT = 5,
    parameter int N_IN = 56
) (
    // Inputs and static masks
    input  wire logic [N_IN-1:0]            in_bus,
    input  wire logic [N_PT-1:0][N_IN-1:0]  use_true,
    input  wire logic [N_PT-1:0][N_IN-1:0]  use_comp,
    // Terms
    output logic      [N_PT-1:0]            pt
);
    always_comb begin
        for (int i = 0; i < N_PT; i++) begin
            pt[i] = (&(~use_true[i] | in_bus)) & (&(~use_comp[i] | ~in_bus));
        end
    end
endmodule : pmc_pterm_array

//--- core/pmc_store.sv
// Storage element of the cell: D, T, JK or SR flip-flop, or transparent latch.
// The selected clock is a level sampled on clk; edges are found against its last sample.
`timescale 1ns/1ps
module pmc_store
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   sys_rst,
    // Control
    input  pmc_ff_mode_t mode,
    input  pmc_ctl_t     ctl,
    // State
    output logic         q
);
    logic clk_prev;
    logic rise;
    logic next_q;

    assign rise = ctl.clk_lvl & ~clk_prev;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= ctl.clk_lvl;
        end
    end

    // JK: d is J, aux is K.  SR: d is S, aux is R; S wins when both are high.
    always_comb begin
        next_q = q;
        unique case (mode)
            PMC_FF_D:     next_q = ctl.d;
            PMC_FF_T:     next_q = q ^ ctl.d;
            PMC_FF_JK:    next_q = (ctl.d & ~q) | (~ctl.aux & q);
            PMC_FF_SR:    next_q = ctl.d | (~ctl.aux & q);
            PMC_FF_LATCH: next_q = ctl.d;
            default:      next_q = q;
        endcase
    end

    // Clear beats set; both beat the clock, as the asynchronous pins would
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= `PMC_Q_RESET;
        end else if (ctl.clr) begin
            q <= 1'b0;
        end else if (ctl.set) begin
            q <= 1'b1;
        end else if (mode == PMC_FF_LATCH) begin
            if (ctl.clk_lvl) begin
                q <= next_q;
            end
        end else if (rise && ctl.ce) begin
            q <= next_q;
        end
    end

    a_reset_init: assert property (@(posedge clk) sys_rst |=> q == `PMC_Q_RESET)
        else $error("storage not initialised by reset");
    a_clear_first: assert property (@(posedge clk) disable iff (sys_rst)
        ctl.clr |=> !q)
        else $error("clear did not win");
endmodule : pmc_store

//--- include/pmc_cfg.svh
// Constants of the programmable logic cell: counts, widths and reset values.
// Included by the package; nothing here depends on any other file.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_NUM_PT      5
`define PMC_MATRIX_IN   40
`define PMC_REGION      16
`define PMC_CELLS       128
`define PMC_PINS        100
`define PMC_CASCADE_MAX 40
`define PMC_FOLD_MAX    21
`define PMC_OE_PINS     2
`define PMC_SEL_W       8
`define PMC_FOLD_SEL_W  3
`define PMC_Q_RESET     1'b0

`endif

//--- include/pmc_pkg.sv
// Types shared by the logic cell and its storage element.
// Expects pmc_cfg.svh on the include path.
package pmc_pkg;
`include "pmc_cfg.svh"

    typedef enum logic [2:0] {
        PMC_PT_SUM, PMC_PT_XOR, PMC_PT_DIN, PMC_PT_CLK,
        PMC_PT_CE, PMC_PT_CLR, PMC_PT_SET
    } pmc_pt_dest_t;

    typedef enum logic [1:0] {PMC_XOR_PT, PMC_XOR_HIGH, PMC_XOR_LOW} pmc_xor_sel_t;
    typedef enum logic [1:0] {PMC_DIN_XOR, PMC_DIN_PT, PMC_DIN_PIN} pmc_din_sel_t;
    typedef enum logic [2:0] {PMC_FF_D, PMC_FF_T, PMC_FF_JK, PMC_FF_SR, PMC_FF_LATCH} pmc_ff_mode_t;
    typedef enum logic {PMC_CLK_GLOBAL, PMC_CLK_PT} pmc_clk_sel_t;
    typedef enum logic [1:0] {PMC_CLR_GLOBAL, PMC_CLR_PT, PMC_CLR_BOTH, PMC_CLR_OFF} pmc_clr_sel_t;
    typedef enum logic {PMC_SET_PT, PMC_SET_OFF} pmc_set_sel_t;
    typedef enum logic [1:0] {PMC_OE_TRUE, PMC_OE_COMP, PMC_OE_PINS, PMC_OE_CELLS} pmc_oe_sel_t;

    typedef struct packed {
        pmc_pt_dest_t [`PMC_NUM_PT-1:0] pt_dest;
        pmc_xor_sel_t                   xor_sel;
        pmc_din_sel_t                   din_sel;
        pmc_ff_mode_t                   ff_mode;
        pmc_clk_sel_t                   clk_sel;
        logic                           ce_en;
        pmc_clr_sel_t                   clr_sel;
        pmc_set_sel_t                   set_sel;
        logic                           out_reg;
        logic                           fb_reg;
        pmc_oe_sel_t                    oe_sel;
        logic                           oe_pin_idx;
        logic                           input_only;
        logic                           casc_en;
        logic [`PMC_FOLD_SEL_W-1:0]     fold_sel;
    } pmc_cfg_t;

    typedef struct packed {
        logic d;
        logic aux;
        logic clk_lvl;
        logic ce;
        logic clr;
        logic set;
    } pmc_ctl_t;

endpackage : pmc_pkg

//--- tb/pmc_macrocell_tb_top.sv
// Self-checking bench for one programmable logic cell.
// Assumes the neighbour model maps pins 0..4 onto terms 0..4 through an identity switch matrix.
`timescale 1ns/1ps
module pmc_macrocell_tb_top
    import pmc_pkg::*;
;
    logic                    clk = 1'b0;
    logic                    sys_rst = 1'b1;
    pmc_cfg_t                cfg = '0;
    logic [39:0][7:0]        matrix_sel = '0;
    logic [4:0][55:0]        pt_use_true = '0;
    logic [4:0][55:0]        pt_use_comp = '0;
    logic [99:0]             oe_pin_mask = 100'h20;
    logic [127:0]            oe_cell_mask = 128'h1;
    logic [99:0]             pins = '0;
    logic [227:0]            global_bus;
    logic [15:0]             foldback_bus;
    logic                    casc = 1'b0;
    logic                    gclk = 1'b0;
    logic                    gclr = 1'b0;
    logic [1:0]              oe_pins = 2'b00;
    logic                    pin_in = 1'b0;
    logic                    pin_out;
    logic                    pin_oe;
    logic                    cascade_out;
    logic                    foldback_out;
    logic                    feedback_out;
    int                      err_count = 0;
    int                      compares = 0;
    pmc_cfg_t                c;

    initial begin
        forever #5 clk = ~clk;
    end

    pmc_nbr_model NBR (.pin_drive(pins), .cell_fb(feedback_out), .cell_fold(foldback_out),
                       .global_bus(global_bus), .foldback_bus(foldback_bus));

    pmc_macrocell DUT (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .matrix_sel(matrix_sel),
                       .pt_use_true(pt_use_true), .pt_use_comp(pt_use_comp), .oe_pin_mask(oe_pin_mask),
                       .oe_cell_mask(oe_cell_mask), .global_bus(global_bus), .foldback_bus(foldback_bus),
                       .cascade_input(casc), .global_clock_line(gclk), .global_clear_line(gclr),
                       .oe_pins(oe_pins), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
                       .cascade_out(cascade_out), .foldback_out(foldback_out), .feedback_out(feedback_out));

    task automatic final_report();
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic chk(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask : chk

    // Configuration may only change under reset, so every scenario starts here
    task automatic setup(input pmc_cfg_t nc, input int n);
        sys_rst = 1'b1;
        cfg = nc;
        pins = '0;
        tick(n);
        sys_rst = 1'b0;
        tick(1);
    endtask : setup

    // Storage takes the edge and pin_out shows it a cycle later, hence two cycles high; the low side gives the needed low sample
    task automatic pulse();
        gclk = 1'b1;
        tick(2);
        gclk = 1'b0;
        tick(2);
    endtask : pulse

    function automatic pmc_cfg_t base_cfg();
        pmc_cfg_t b;
        b = '0;
        b.xor_sel = PMC_XOR_LOW;
        b.clr_sel = PMC_CLR_OFF;
        b.set_sel = PMC_SET_OFF;
        return b;
    endfunction : base_cfg

    initial begin
        #500000;
        err_count++;
        final_report();
    end

    initial begin
        for (int i = 0; i < 40; i++) matrix_sel[i] = 8'(i);
        for (int k = 0; k < 5; k++) pt_use_true[k][k] = 1'b1;
        c = base_cfg();
        setup(c, 10);
        chk(pin_out, 1'b0, "reset output");
        for (int k = 0; k < 6; k++) begin
            pins = '0;
            if (k < 5) pins[k] = 1'b1;
            tick(1);
            chk(pin_out, k < 5, "or sum");
            chk(cascade_out, k < 5, "sum to cascade");
            chk(foldback_out, k != 0, "foldback inverse");
        end
        c.xor_sel = PMC_XOR_HIGH;
        setup(c, 2);
        chk(pin_out, 1'b1, "inverted polarity");
        c.xor_sel = PMC_XOR_PT;
        c.pt_dest[4] = PMC_PT_XOR;
        setup(c, 2);
        pins[4:0] = 5'h11;
        tick(1);
        chk(pin_out, 1'b0, "xor with term");
        c = base_cfg();
        c.casc_en = 1'b1;
        setup(c, 2);
        casc = 1'b1;
        tick(1);
        chk(pin_out, 1'b1, "cascade in");
        chk(cascade_out, 1'b1, "cascade chain");
        casc = 1'b0;
        c = base_cfg();
        c.out_reg = 1'b1;
        c.clr_sel = PMC_CLR_GLOBAL;
        c.ce_en = 1'b1;
        c.pt_dest[4] = PMC_PT_CE;
        setup(c, 2);
        pins[4:0] = 5'h11;
        tick(2);
        chk(pin_out, 1'b0, "no edge no update");
        pulse();
        chk(pin_out, 1'b1, "global clock edge");
        pins[4:0] = 5'h00;
        tick(1);
        chk(pin_out, 1'b1, "registered output");
        chk(feedback_out, 1'b0, "combinational feedback");
        pulse();
        chk(pin_out, 1'b1, "edge ignored");
        pins[4:0] = 5'h10;
        pulse();
        chk(pin_out, 1'b0, "edge enabled");
        pins[4:0] = 5'h11;
        pulse();
        gclr = 1'b1;
        tick(2);
        chk(pin_out, 1'b0, "global clear");
        gclr = 1'b0;
        c = base_cfg();
        c.out_reg = 1'b1;
        c.fb_reg = 1'b1;
        c.clk_sel = PMC_CLK_PT;
        c.pt_dest[3] = PMC_PT_CLK;
        c.pt_dest[2] = PMC_PT_SET;
        c.set_sel = PMC_SET_PT;
        setup(c, 2);
        pins[2] = 1'b1;
        tick(2);
        chk(pin_out, 1'b1, "term set");
        chk(feedback_out, 1'b1, "registered feedback");
        pins[2] = 1'b0;
        pins[3] = 1'b1;
        tick(2);
        chk(pin_out, 1'b0, "term clock edge");
        c = base_cfg();
        c.out_reg = 1'b1;
        c.ff_mode = PMC_FF_T;
        c.din_sel = PMC_DIN_PIN;
        setup(c, 2);
        pin_in = 1'b1;
        pulse();
        chk(pin_out, 1'b1, "toggle from pin");
        pulse();
        chk(pin_out, 1'b0, "toggle back");
        pin_in = 1'b0;
        c.ff_mode = PMC_FF_LATCH;
        c.din_sel = PMC_DIN_XOR;
        setup(c, 2);
        gclk = 1'b1;
        pins[0] = 1'b1;
        tick(3);
        chk(pin_out, 1'b1, "latch transparent");
        gclk = 1'b0;
        tick(2);
        pins[0] = 1'b0;
        tick(3);
        chk(pin_out, 1'b1, "latch holds");
        gclk = 1'b1;
        tick(3);
        chk(pin_out, 1'b0, "latch follows");
        gclk = 1'b0;
        // JK toggles on both inputs high, SR lets set win
        c = base_cfg();
        c.out_reg = 1'b1;
        c.pt_dest[4] = PMC_PT_XOR;
        for (int m = 0; m < 2; m++) begin
            c.ff_mode = (m == 0) ? PMC_FF_JK : PMC_FF_SR;
            setup(c, 2);
            pins[4:0] = 5'h11;
            pulse();
            chk(pin_out, 1'b1, "both inputs from low");
            pulse();
            chk(pin_out, m == 1, "both inputs from high");
            pins[4:0] = 5'h10;
            pulse();
            chk(pin_out, 1'b0, "second input clears");
        end
        c = base_cfg();
        c.out_reg = 1'b1;
        c.din_sel = PMC_DIN_PT;
        c.clr_sel = PMC_CLR_BOTH;
        c.pt_dest[2] = PMC_PT_DIN;
        c.pt_dest[3] = PMC_PT_CLR;
        setup(c, 2);
        pins[2] = 1'b1;
        pulse();
        chk(pin_out, 1'b1, "dedicated data term");
        pins[3] = 1'b1;
        tick(2);
        chk(pin_out, 1'b0, "clear term");
        pins[3] = 1'b0;
        pulse();
        chk(pin_out, 1'b1, "data after clear");
        gclr = 1'b1;
        tick(2);
        chk(pin_out, 1'b0, "global side of clear or");
        gclr = 1'b0;
        // Term 0 reads only its own foldback; term 1 is kept out of the sum
        c = base_cfg();
        c.fold_sel = 3'h1;
        c.pt_dest[1] = PMC_PT_CE;
        pt_use_true[0] = 56'h0;
        pt_use_true[0][40] = 1'b1;
        setup(c, 2);
        tick(1);
        chk(pin_out, 1'b1, "foldback bus as input");
        pins[1] = 1'b1;
        tick(2);
        chk(pin_out, 1'b0, "selected foldback term");
        chk(foldback_out, 1'b0, "selected term inverted");
        pt_use_true[0] = 56'h1;
        for (int m = 0; m < 4; m++) begin
            c = base_cfg();
            c.oe_sel = m[0] ? PMC_OE_COMP : PMC_OE_TRUE;
            c.oe_pin_idx = m[1];
            setup(c, 2);
            oe_pins = 2'b01;
            tick(1);
            chk(pin_oe, m[0] ^ !m[1], "enable pin form");
            oe_pins = 2'b10;
            tick(1);
            chk(pin_oe, m[0] ^ m[1], "enable pin form");
        end
        c.oe_sel = PMC_OE_PINS;
        setup(c, 2);
        pins[5] = 1'b1;
        tick(1);
        chk(pin_oe, 1'b1, "enable pin subset");
        c.input_only = 1'b1;
        setup(c, 2);
        pins[5] = 1'b1;
        pins[0] = 1'b1;
        tick(1);
        chk(pin_oe, 1'b0, "input only");
        chk(foldback_out, 1'b0, "foldback while input only");
        chk(cascade_out, 1'b1, "cascade while input only");
        c = base_cfg();
        c.oe_sel = PMC_OE_CELLS;
        setup(c, 2);
        pins[0] = 1'b1;
        tick(2);
        chk(feedback_out, 1'b1, "feedback on global bus");
        chk(pin_oe, 1'b1, "enable cell subset");
        final_report();
    end
endmodule : pmc_macrocell_tb_top

//--- tb/pmc_nbr_model.sv
// Neighbour model: the device pins, the other cells and the regional foldback bus.
// Assumes the cell under test sits at cell index 0 and at foldback slot 0.
`timescale 1ns/1ps
module pmc_nbr_model (
    // Pin levels set by the bench
    input  wire logic [99:0]  pin_drive,
    // Cell under test
    input  wire logic         cell_fb,
    input  wire logic         cell_fold,
    // Shared buses
    output logic      [227:0] global_bus,
    output logic      [15:0]  foldback_bus
);
    // Other cells idle low on the global bus; their foldback terms idle high
    assign global_bus   = {127'h0, cell_fb, pin_drive};
    assign foldback_bus = {15'h7FFF, cell_fold};
endmodule : pmc_nbr_model
